// ==== ettc_pkg.sv ====
package ettc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int FLAG_W = 3;

  // register map, byte offsets on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CMP_A  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMP_B  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_FLAG   = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h6;

  localparam logic [DATA_W-1:0] RESET_VAL  = 8'h00;
  localparam logic [DATA_W-1:0] BOTTOM_VAL = 8'h00;
  localparam logic [DATA_W-1:0] MAX_VAL    = 8'hFF;
  localparam logic [DATA_W-1:0] STEP_VAL   = 8'h01;

  // control_register_a fields
  localparam int CA_WGM_LO  = 0;
  localparam int CA_COMB_LO = 4;
  localparam int CA_COMA_LO = 6;
  // control_register_b fields
  localparam int CB_CS_LO = 0;
  localparam int CB_WGM2  = 3;
  localparam int CB_FOCB  = 6;
  localparam int CB_FOCA  = 7;
  localparam logic [DATA_W-1:0] CB_READ_MASK = 8'h0F;
  // timer_flag_register and timer_mask_register bits
  localparam int FLAG_OVF  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;

  // waveform_mode_field values
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC       = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
  localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP  = 3'h7;

  // clock_select_field values
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // prescaler taps: tick when all masked bits are one
  localparam logic [9:0] TAP_DIV8    = 10'h007;
  localparam logic [9:0] TAP_DIV64   = 10'h03F;
  localparam logic [9:0] TAP_DIV256  = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

  // compare output actions
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef enum logic [2:0] {
    ETTC_NONPWM = 3'b001,
    ETTC_FAST   = 3'b010,
    ETTC_PHASE  = 3'b100
  } ettc_kind_type;

  typedef enum logic [1:0] {
    ETTC_UP   = 2'b01,
    ETTC_DOWN = 2'b10
  } ettc_dir_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ettc_bus_type;

  typedef struct packed {
    logic match;
    logic top;
    logic force_hit;
    logic up;
  } ettc_wave_ev_type;

endpackage

// ==== ettc_clksel.sv ====
`timescale 1ns/100ps
module ettc_clksel #(
  parameter int PRE_W = 10
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       external_clock_pin,
  output logic            timer_tick
);
  import ettc_pkg::*;

  logic [PRE_W-1:0] pre_q;
  logic             pin_s1_q;
  logic             pin_s2_q;
  logic             pin_s3_q;
  logic             tick_d;

  function automatic logic tap_hit(input logic [PRE_W-1:0] pre, input logic [9:0] tap);
    tap_hit = (pre[9:0] & tap) == tap;
  endfunction

  // free running prescaler
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // pin synchroniser and edge history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= external_clock_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // source and edge choice
  always_comb begin
    case (clock_select_field)
      CS_STOP:     tick_d = 1'b0;
      CS_DIV1:     tick_d = 1'b1;
      CS_DIV8:     tick_d = tap_hit(pre_q, TAP_DIV8);
      CS_DIV64:    tick_d = tap_hit(pre_q, TAP_DIV64);
      CS_DIV256:   tick_d = tap_hit(pre_q, TAP_DIV256);
      CS_DIV1024:  tick_d = tap_hit(pre_q, TAP_DIV1024);
      CS_EXT_FALL: tick_d = pin_s3_q & ~pin_s2_q;
      default:     tick_d = pin_s2_q & ~pin_s3_q;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= tick_d;
    end
  end

endmodule

// ==== ettc_wavegen.sv ====
`timescale 1ns/100ps
module ettc_wavegen (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [1:0]                 com,
  input  wire ettc_pkg::ettc_kind_type    kind,
  input  wire ettc_pkg::ettc_wave_ev_type ev,
  output logic                            wave
);
  import ettc_pkg::*;

  // output compare state, drives the compare output pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wave <= 1'b0;
    end else if (ev.match || ev.force_hit) begin
      case (kind)
        ETTC_NONPWM: begin
          if (com == COM_TOGGLE) begin
            wave <= ~wave;
          end else if (com == COM_CLEAR) begin
            wave <= 1'b0;
          end else if (com == COM_SET) begin
            wave <= 1'b1;
          end
        end
        ETTC_FAST: begin
          if (com == COM_CLEAR) begin
            wave <= 1'b0;
          end else if (com == COM_SET) begin
            wave <= 1'b1;
          end
        end
        default: begin
          if (com == COM_CLEAR) begin
            wave <= ~ev.up;
          end else if (com == COM_SET) begin
            wave <= ev.up;
          end
        end
      endcase
    end else if (ev.top && kind == ETTC_FAST) begin
      if (com == COM_CLEAR) begin
        wave <= 1'b1;
      end else if (com == COM_SET) begin
        wave <= 1'b0;
      end
    end
  end

endmodule

// ==== ettc_core.sv ====
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module ettc_core (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire ettc_pkg::ettc_bus_type bus,
  output logic [7:0]                 rdata,
  input  wire logic                  external_clock_pin,
  output logic                       compare_output_a,
  output logic                       compare_output_b,
  output logic                       irq_overflow,
  output logic                       irq_compare_a,
  output logic                       irq_compare_b
);
  import ettc_pkg::*;

  logic [DATA_W-1:0] control_register_a_q;
  logic [DATA_W-1:0] control_register_b_q;
  logic [DATA_W-1:0] counter_value_q;
  logic [DATA_W-1:0] counter_value_d;
  logic [DATA_W-1:0] compare_value_a_q;
  logic [DATA_W-1:0] compare_value_b_q;
  logic [FLAG_W-1:0] timer_flag_register_q;
  logic [FLAG_W-1:0] timer_mask_register_q;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  ettc_dir_type      dir_q;
  ettc_dir_type      dir_d;
  logic              block_q;
  logic [2:0]        waveform_mode_field;
  logic [2:0]        clock_select_field;
  ettc_kind_type     kind;
  logic [DATA_W-1:0] top_val;
  logic              timer_tick;
  logic              wr_count;
  logic              at_top;
  logic              at_bottom;
  logic              match_a;
  logic              match_b;
  logic              go_up;
  logic              ovf_evt;
  logic              cmpa_evt;
  logic              cmpb_evt;
  ettc_wave_ev_type  ev_a;
  ettc_wave_ev_type  ev_b;

  function automatic logic wr_hit(input ettc_bus_type b, input logic [ADDR_W-1:0] a);
    wr_hit = b.wr && b.addr == a;
  endfunction

  function automatic ettc_kind_type kind_of(input logic [2:0] m);
    if (m == MODE_PHASE_MAX || m == MODE_PHASE_CMP) begin
      kind_of = ETTC_PHASE;
    end else if (m == MODE_FAST_MAX || m == MODE_FAST_CMP) begin
      kind_of = ETTC_FAST;
    end else begin
      kind_of = ETTC_NONPWM;
    end
  endfunction

  assign waveform_mode_field = {control_register_b_q[CB_WGM2],
                                control_register_a_q[CA_WGM_LO+:2]};
  assign clock_select_field  = control_register_b_q[CB_CS_LO+:3];
  assign kind                = kind_of(waveform_mode_field);
  assign top_val             = (waveform_mode_field == MODE_CTC ||
                                waveform_mode_field == MODE_PHASE_CMP ||
                                waveform_mode_field == MODE_FAST_CMP)
                               ? compare_value_a_q : MAX_VAL;
  assign wr_count            = wr_hit(bus, ADDR_COUNT);
  assign at_top              = counter_value_q == top_val;
  assign at_bottom           = counter_value_q == BOTTOM_VAL;
  assign match_a             = counter_value_q == compare_value_a_q;
  assign match_b             = counter_value_q == compare_value_b_q;

  ettc_clksel u_clksel (
    .clock              (clock),
    .rst                (rst),
    .clock_select_field (clock_select_field),
    .external_clock_pin (external_clock_pin),
    .timer_tick         (timer_tick)
  );

  // direction of the next step
  always_comb begin
    case (dir_q)
      ETTC_UP:   go_up = !at_top;
      ETTC_DOWN: go_up = at_bottom;
      default:   go_up = 1'b1;
    endcase
    if (kind != ETTC_PHASE) begin
      go_up = 1'b1;
    end
    dir_d = go_up ? ETTC_UP : ETTC_DOWN;
  end

  // next count per mode
  always_comb begin
    if (kind == ETTC_PHASE) begin
      counter_value_d = go_up ? counter_value_q + STEP_VAL
                              : counter_value_q - STEP_VAL;
    end else if (at_top && waveform_mode_field != MODE_NORMAL) begin
      counter_value_d = BOTTOM_VAL;
    end else begin
      counter_value_d = counter_value_q + STEP_VAL;
    end
  end

  assign ovf_evt  = timer_tick && !wr_count &&
                    ((kind == ETTC_PHASE) ? (dir_q == ETTC_DOWN && at_bottom)
                                          : (counter_value_d == BOTTOM_VAL &&
                                             counter_value_q == MAX_VAL));
  assign cmpa_evt = timer_tick && match_a && !block_q;
  assign cmpb_evt = timer_tick && match_b && !block_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      counter_value_q <= RESET_VAL;
    end else if (wr_count) begin
      counter_value_q <= bus.wdata;
    end else if (timer_tick) begin
      counter_value_q <= counter_value_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_q <= ETTC_UP;
    end else if (timer_tick) begin
      dir_q <= dir_d;
    end
  end

  // a count write blocks matches up to and including the next tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control_register_a_q <= RESET_VAL;
      control_register_b_q <= RESET_VAL;
      compare_value_a_q    <= RESET_VAL;
      compare_value_b_q    <= RESET_VAL;
      timer_mask_register_q <= '0;
    end else begin
      if (wr_hit(bus, ADDR_CTRL_A)) begin
        control_register_a_q <= bus.wdata;
      end
      if (wr_hit(bus, ADDR_CTRL_B)) begin
        control_register_b_q <= bus.wdata & CB_READ_MASK;
      end
      if (wr_hit(bus, ADDR_CMP_A)) begin
        compare_value_a_q <= bus.wdata;
      end
      if (wr_hit(bus, ADDR_CMP_B)) begin
        compare_value_b_q <= bus.wdata;
      end
      if (wr_hit(bus, ADDR_MASK)) begin
        timer_mask_register_q <= bus.wdata[FLAG_W-1:0];
      end
    end
  end

  // flags: write one clears, a same-cycle set wins
  assign flag_set = {cmpb_evt, cmpa_evt, ovf_evt};
  assign flag_clr = wr_hit(bus, ADDR_FLAG) ? bus.wdata[FLAG_W-1:0] : '0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_flag_register_q <= '0;
    end else begin
      timer_flag_register_q <= (timer_flag_register_q & ~flag_clr) | flag_set;
    end
  end

  assign irq_overflow  = timer_flag_register_q[FLAG_OVF] & timer_mask_register_q[FLAG_OVF];
  assign irq_compare_a = timer_flag_register_q[FLAG_CMPA] &
                         timer_mask_register_q[FLAG_CMPA];
  assign irq_compare_b = timer_flag_register_q[FLAG_CMPB] &
                         timer_mask_register_q[FLAG_CMPB];

  // read data, one cycle after the read strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= RESET_VAL;
    end else if (bus.rd) begin
      if (bus.addr == ADDR_CTRL_A) begin
        rdata <= control_register_a_q;
      end else if (bus.addr == ADDR_CTRL_B) begin
        rdata <= control_register_b_q;
      end else if (bus.addr == ADDR_COUNT) begin
        rdata <= counter_value_q;
      end else if (bus.addr == ADDR_CMP_A) begin
        rdata <= compare_value_a_q;
      end else if (bus.addr == ADDR_CMP_B) begin
        rdata <= compare_value_b_q;
      end else if (bus.addr == ADDR_FLAG) begin
        rdata <= {{(DATA_W-FLAG_W){1'b0}}, timer_flag_register_q};
      end else if (bus.addr == ADDR_MASK) begin
        rdata <= {{(DATA_W-FLAG_W){1'b0}}, timer_mask_register_q};
      end else begin
        rdata <= RESET_VAL;
      end
    end
  end

  // waveform events; force only acts in non-pwm modes
  assign ev_a.match     = cmpa_evt;
  assign ev_a.top       = timer_tick && at_top;
  assign ev_a.force_hit = wr_hit(bus, ADDR_CTRL_B) && bus.wdata[CB_FOCA] &&
                          kind == ETTC_NONPWM;
  assign ev_a.up        = dir_q == ETTC_UP;
  assign ev_b.match     = cmpb_evt;
  assign ev_b.top       = timer_tick && at_top;
  assign ev_b.force_hit = wr_hit(bus, ADDR_CTRL_B) && bus.wdata[CB_FOCB] &&
                          kind == ETTC_NONPWM;
  assign ev_b.up        = dir_q == ETTC_UP;

  ettc_wavegen u_wave_a (
    .clock (clock),
    .rst   (rst),
    .com   (control_register_a_q[CA_COMA_LO+:2]),
    .kind  (kind),
    .ev    (ev_a),
    .wave  (compare_output_a)
  );

  ettc_wavegen u_wave_b (
    .clock (clock),
    .rst   (rst),
    .com   (control_register_a_q[CA_COMB_LO+:2]),
    .kind  (kind),
    .ev    (ev_b),
    .wave  (compare_output_b)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  count_write_a: assert property (
    wr_count |=> counter_value_q == $past(bus.wdata))
    else $error("count write not stored");

  stop_hold_a: assert property (
    clock_select_field == CS_STOP && $past(clock_select_field) == CS_STOP
    && !wr_count |=> $stable(counter_value_q))
    else $error("count moved while stopped");

  normal_step_a: assert property (
    timer_tick && !wr_count && waveform_mode_field == MODE_NORMAL
    |=> counter_value_q == $past(counter_value_q) + STEP_VAL)
    else $error("normal mode did not step up by one");

  ovf_wrap_a: assert property (
    timer_tick && !wr_count && waveform_mode_field == MODE_NORMAL
    && counter_value_q == MAX_VAL
    |=> counter_value_q == BOTTOM_VAL && timer_flag_register_q[FLAG_OVF])
    else $error("wrap did not raise overflow");

  ctc_clear_a: assert property (
    timer_tick && !wr_count && waveform_mode_field == MODE_CTC && match_a
    |=> counter_value_q == BOTTOM_VAL)
    else $error("ctc did not clear on match a");

  cmp_flag_a: assert property (
    timer_tick && match_a && !block_q |=> timer_flag_register_q[FLAG_CMPA])
    else $error("match a did not set flag a");

  write_block_a: assert property (
    block_q && timer_tick && !wr_hit(bus, ADDR_FLAG)
    |=> timer_flag_register_q[FLAG_CMPB] == $past(timer_flag_register_q[FLAG_CMPB]))
    else $error("match not blocked after count write");

  set_wins_a: assert property (
    ovf_evt && flag_clr[FLAG_OVF] |=> timer_flag_register_q[FLAG_OVF])
    else $error("clear beat a same-cycle overflow");

  count_read_a: assert property (
    bus.rd && bus.addr == ADDR_COUNT |=> rdata == $past(counter_value_q))
    else $error("count read returned wrong value");

  irq_gate_a: assert property (
    !timer_mask_register_q[FLAG_CMPB] |-> !irq_compare_b)
    else $error("masked request leaked");

  wrap_cover: cover property (ovf_evt ##1 irq_overflow);
  ctc_cover: cover property (waveform_mode_field == MODE_CTC && cmpa_evt);
  block_cover: cover property (block_q && timer_tick && match_b);
  phase_cover: cover property (kind == ETTC_PHASE && dir_q == ETTC_DOWN ##1 ovf_evt);

endmodule

// ==== ettc_core_bench.sv ====
`timescale 1ns/100ps
module ettc_core_bench;
  import ettc_pkg::*;
  logic         clock;
  logic         rst;
  ettc_bus_type bus;
  logic [7:0]   rdata;
  logic         external_clock_pin;
  logic         compare_output_a;
  logic         compare_output_b;
  logic         irq_overflow;
  logic         irq_compare_a;
  logic         irq_compare_b;
  logic [2:0]   irqs;
  int           miscompares;
  int           n_compared;

  assign irqs = {irq_compare_b, irq_compare_a, irq_overflow};

  ettc_core i_ettc_core (
    .clock              (clock),
    .rst                (rst),
    .bus                (bus),
    .rdata              (rdata),
    .external_clock_pin (external_clock_pin),
    .compare_output_a   (compare_output_a),
    .compare_output_b   (compare_output_b),
    .irq_overflow       (irq_overflow),
    .irq_compare_a      (irq_compare_a),
    .irq_compare_b      (irq_compare_b)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write cycle, then one idle cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask

  // read data are taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 d = rdata;
    @(posedge clock);
  endtask

  task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, exp, d);
  endtask

  task automatic wait_irq(input int sel, output int n);
    n = 0;
    while (irqs[sel] !== 1'b1 && n < 600) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("irq wait", 8'h01, {7'h00, n < 600});
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      external_clock_pin <= 1'b1;
      repeat (6) @(posedge clock);
      external_clock_pin <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask

  task automatic t_reset_values;
    for (int a = 0; a < 8; a++) begin
      rdchk("reset value", 4'(a), 8'h00);
    end
    check("irq after reset", 8'h00, {5'h00, irqs});
  endtask

  task automatic t_registers;
    wr(ADDR_CMP_A, 8'hA5);
    wr(ADDR_CMP_B, 8'h5A);
    wr(ADDR_COUNT, 8'h37);
    wr(ADDR_CTRL_B, 8'h38);
    wr(ADDR_MASK, 8'h07);
    wr(4'hF, 8'hFF);
    rdchk("compare a", ADDR_CMP_A, 8'hA5);
    rdchk("compare b", ADDR_CMP_B, 8'h5A);
    rdchk("control b", ADDR_CTRL_B, 8'h08);
    rdchk("mask", ADDR_MASK, 8'h07);
    rdchk("unmapped", 4'hF, 8'h00);
    repeat (20) @(posedge clock);
    rdchk("stopped count", ADDR_COUNT, 8'h37);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_MASK, 8'h00);
  endtask

  task automatic t_overflow;
    int n;
    wr(ADDR_CMP_A, 8'h80);
    wr(ADDR_CMP_B, 8'h81);
    wr(ADDR_COUNT, 8'hFD);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    wait_irq(0, n);
    check("overflow delay", 8'h01, {7'h00, n >= 2 && n <= 6});
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    rdchk("flags", ADDR_FLAG, 8'h01);
    wr(ADDR_MASK, 8'h00);
    check("masked overflow", 8'h00, {7'h00, irq_overflow});
    wr(ADDR_FLAG, 8'h01);
    rdchk("flags cleared", ADDR_FLAG, 8'h00);
  endtask

  task automatic t_compare;
    int n;
    int m;
    wr(ADDR_COUNT, 8'h08);
    wr(ADDR_CMP_A, 8'h10);
    wr(ADDR_CMP_B, 8'h20);
    wr(ADDR_MASK, 8'h06);
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    wait_irq(1, n);
    check("b before a", 8'h00, {7'h00, irq_compare_b});
    wait_irq(2, m);
    check("match spacing", 8'h10, 8'(m));
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    rdchk("compare flags", ADDR_FLAG, 8'h06);
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_MASK, 8'h00);
  endtask

  task automatic t_ctc;
    logic [7:0] d;
    wr(ADDR_CTRL_A, 8'(MODE_CTC));
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    repeat (40) @(posedge clock);
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    rd(ADDR_COUNT, d);
    check("ctc top", 8'h01, {7'h00, d <= 8'h05});
    rdchk("ctc flags", ADDR_FLAG, 8'h02);
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_CTRL_A, 8'(MODE_NORMAL));
  endtask

  task automatic t_blocking;
    wr(ADDR_CMP_A, 8'h40);
    wr(ADDR_CMP_B, 8'h40);
    wr(ADDR_COUNT, 8'h40);
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    repeat (20) @(posedge clock);
    rdchk("blocked flags", ADDR_FLAG, 8'h00);
    wr(ADDR_COUNT, 8'h90);
    rdchk("write beats tick", ADDR_COUNT, 8'h91);
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    wr(ADDR_FLAG, 8'h07);
  endtask

  task automatic t_clock_sources;
    logic [7:0] d;
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'(CS_EXT_RISE));
    pulses(5);
    rdchk("rising edges", ADDR_COUNT, 8'h05);
    wr(ADDR_CTRL_B, 8'(CS_EXT_FALL));
    pulses(5);
    rdchk("falling edges", ADDR_COUNT, 8'h0A);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'(CS_DIV8));
    repeat (80) @(posedge clock);
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    rd(ADDR_COUNT, d);
    check("prescaled ticks", 8'h01, {7'h00, d >= 8'h09 && d <= 8'h0B});
  endtask

  task automatic t_force;
    wr(ADDR_CTRL_A, 8'h70);
    wr(ADDR_CTRL_B, 8'h80);
    repeat (3) @(posedge clock);
    check("output a toggled", 8'h01, {7'h00, compare_output_a});
    rdchk("force reads zero", ADDR_CTRL_B, 8'h00);
    wr(ADDR_CTRL_B, 8'h80);
    repeat (3) @(posedge clock);
    check("output a back", 8'h00, {7'h00, compare_output_a});
    wr(ADDR_CTRL_B, 8'h40);
    repeat (3) @(posedge clock);
    check("output b set", 8'h01, {7'h00, compare_output_b});
  endtask

  // phase correct overflow only at bottom on the way down; fast sets output a at top
  task automatic t_pwm;
    int n;
    wr(ADDR_CTRL_A, 8'(MODE_PHASE_MAX));
    wr(ADDR_COUNT, 8'hFD);
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    wait_irq(0, n);
    check("phase overflow", 8'h01, {7'h00, n >= 256 && n <= 260});
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_CTRL_A, 8'h83);
    wr(ADDR_COUNT, 8'hFD);
    wr(ADDR_CTRL_B, 8'(CS_DIV1));
    repeat (10) @(posedge clock);
    wr(ADDR_CTRL_B, 8'(CS_STOP));
    check("fast top sets a", 8'h01, {7'h00, compare_output_a});
    wr(ADDR_FLAG, 8'h07);
  endtask

  initial begin
    miscompares = 0;
    n_compared = 0;
    rst = 1'b1;
    bus = '0;
    external_clock_pin = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset_values();
    t_registers();
    t_overflow();
    t_compare();
    t_ctc();
    t_blocking();
    t_clock_sources();
    t_force();
    t_pwm();
    finish_test();
  end

  // cut a hang short
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    finish_test();
  end
endmodule
